// File: rtl/uart_bit_timer.sv
// bit period timer: counts 16+k prescaled ticks, marks bit middle and end
`timescale 1ns/1ps
module uart_bit_timer
  import uart_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic presc_tick_i,
  input wire logic [3:0] div_sel_i,
  output logic mid_o,
  output logic end_o
);

  logic [4:0] count_r, count_nxt;
  logic mid_r, mid_nxt, end_r, end_nxt;
  logic [4:0] last;

  // next count; the all-ones divider code simply gives a period of 31
  always_comb begin
    last = DIV_BASE + {1'b0, div_sel_i} - 5'h01;
    count_nxt = count_r;
    mid_nxt = 1'b0;
    end_nxt = 1'b0;
    if (restart_i) begin
      count_nxt = 5'h00;
    end else if (presc_tick_i) begin
      mid_nxt = (count_r == {1'b0, last[4:1]});
      end_nxt = (count_r == last);
      count_nxt = (count_r == last) ? 5'h00 : count_r + 5'h01;
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_r <= 5'h00;
      mid_r <= 1'b0;
      end_r <= 1'b0;
    end else if (ce_i) begin
      count_r <= count_nxt;
      mid_r <= mid_nxt;
      end_r <= end_nxt;
    end
  end

  assign mid_o = mid_r;
  assign end_o = end_r;

endmodule // uart_bit_timer

// File: rtl/uart_core.sv
// asynchronous serial interface: registers, baud generator, transmitter,
// receiver and error reporting
//
// Summary of operation
// - char length bit 0 gives 7-bit characters, 1 gives 8-bit.
// - stop length bit 0 sends one stop bit, 1 sends two.
// - error gating bit 1 suppresses receive-complete interrupt on errors.
// - error status register reads as a byte, resets to 00H.
// - parity error flag set when received parity mismatches mode.
// - framing error flag set when stop bit is not high.
// - overrun flag set when a character completes into an unread buffer.
// - receiver checks only one stop bit regardless of stop length.
// - overrun repeats for every character until the buffer is read.
// - baud register sets serial clock, resets 00H, bit 7 reads 0.
// - prescale field v selects main clock divided by 2^(v+1).
// - divider field k divides prescaled clock by 16+k; k=15 prohibited (the timer still accepts it and divides by 31).
// - both enables clear: no transfers, both pins are plain ports.
// - enable pair selects stop, receive, transmit or full duplex.
// - parity: none, zero sent unchecked, odd, even.
// - complete character goes to receive buffer; 7-bit leaves MSB 0.
// - writing transmit data starts a framed transmission.
`timescale 1ns/1ps
module uart_core
  import uart_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [15:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic rx_pin_serial_o,
  output logic tx_pin_serial_o,
  output logic rx_done_irq_o,
  output logic tx_busy_o
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  mode_t mode_r, mode_nxt;
  baud_t baud_r, baud_nxt;
  logic [7:0] stat_r, stat_nxt, rdata_r, rdata_nxt;
  logic [7:0] rx_buf_r, rx_buf_nxt;
  logic rx_full_r, rx_full_nxt;
  logic wr_mode, wr_baud, wr_data, rd_stat, rd_data;
  logic rx_done, rx_pe, rx_fe, rx_ove;
  logic [7:0] rx_char;
  parity_t par_mode;

  assign wr_mode = sfr_wr_i && (sfr_addr_i == ADDR_MODE);
  assign wr_baud = sfr_wr_i && (sfr_addr_i == ADDR_BAUD);
  assign wr_data = sfr_wr_i && (sfr_addr_i == ADDR_DATA);
  assign rd_stat = sfr_rd_i && (sfr_addr_i == ADDR_STAT);
  assign rd_data = sfr_rd_i && (sfr_addr_i == ADDR_DATA);
  assign par_mode = parity_t'({mode_r.parity_select_hi,
                               mode_r.parity_select_lo});

  // register writes, read mux, status and buffer updates
  always_comb begin
    mode_nxt = mode_r;
    baud_nxt = baud_r;
    if (wr_mode) begin
      mode_nxt = mode_t'(sfr_wdata_i);
      mode_nxt.zero = 1'b0;
    end
    if (wr_baud) begin
      baud_nxt = baud_t'(sfr_wdata_i);
      baud_nxt.zero = 1'b0;
    end
    // a read clears the flags, a new error in the same cycle wins
    stat_nxt = rd_stat ? STAT_RST : stat_r;
    if (rx_done) begin
      stat_nxt[STAT_PE_BIT] = stat_nxt[STAT_PE_BIT] | rx_pe;
      stat_nxt[STAT_FE_BIT] = stat_nxt[STAT_FE_BIT] | rx_fe;
      stat_nxt[STAT_OVE_BIT] = stat_nxt[STAT_OVE_BIT] | rx_ove;
    end
    rx_buf_nxt = rx_done ? rx_char : rx_buf_r;
    rx_full_nxt = rx_done | (rx_full_r & ~rd_data);
    unique case (sfr_addr_i)
      ADDR_MODE: rdata_nxt = mode_r;
      ADDR_STAT: rdata_nxt = stat_r;
      ADDR_BAUD: rdata_nxt = baud_r;
      ADDR_DATA: rdata_nxt = rx_buf_r;
      default: rdata_nxt = UNMAPPED_RD;
    endcase
    if (!sfr_rd_i) begin
      rdata_nxt = rdata_r;
    end
  end

  // register state
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_r <= mode_t'(MODE_RST);
      baud_r <= baud_t'(BAUD_RST);
      stat_r <= STAT_RST;
      rdata_r <= UNMAPPED_RD;
      rx_buf_r <= RXBUF_RST;
      rx_full_r <= 1'b0;
    end else if (ce_i) begin
      mode_r <= mode_nxt;
      baud_r <= baud_nxt;
      stat_r <= stat_nxt;
      rdata_r <= rdata_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_full_r <= rx_full_nxt;
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign rx_pin_serial_o = mode_r.receive_enable_bit;
  assign tx_pin_serial_o = mode_r.transmit_enable_bit;

  // ----------------------------------------------------------------------
  // prescaler and bit timers
  // ----------------------------------------------------------------------
  logic [7:0] presc_r, presc_nxt, presc_mask;
  logic presc_tick;
  logic rx_restart, tx_restart, rx_mid, tx_end;

  // free running divider of the main clock; tick every 2^(v+1) cycles
  always_comb begin
    presc_mask = 8'(({PRESC_ONE, 1'b0} << baud_r.prescale_sel) - 9'h001);
    presc_tick = ((presc_r & presc_mask) == presc_mask);
    presc_nxt = presc_r + 8'h01;
  end

  // prescaler counter
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_r <= 8'h00;
    end else if (ce_i) begin
      presc_r <= presc_nxt;
    end
  end

  uart_bit_timer u_rx_timer (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .restart_i(rx_restart),
    .presc_tick_i(presc_tick),
    .div_sel_i(baud_r.divider_sel),
    .mid_o(rx_mid),
    .end_o()
  );

  uart_bit_timer u_tx_timer (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .restart_i(tx_restart),
    .presc_tick_i(presc_tick),
    .div_sel_i(baud_r.divider_sel),
    .mid_o(),
    .end_o(tx_end)
  );

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  ser_state_t rx_state_r, rx_state_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [2:0] rx_cnt_r, rx_cnt_nxt, len_last;
  logic rx_par_r, rx_par_nxt, rx_prev_r, rx_err;
  logic irq_r, irq_nxt;

  assign len_last = mode_r.char_length_bit ? LEN8_LAST : LEN7_LAST;

  // start edge search, mid-bit sampling and character completion
  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_par_nxt = rx_par_r;
    rx_restart = 1'b0;
    rx_done = 1'b0;
    rx_char = mode_r.char_length_bit ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
    rx_fe = !serial_in_pin_i;
    unique case (par_mode)
      PAR_ODD: rx_pe = ~(^{rx_char, rx_par_r});
      PAR_EVEN: rx_pe = ^{rx_char, rx_par_r};
      default: rx_pe = 1'b0;
    endcase
    rx_ove = rx_full_r && !rd_data;
    unique case (rx_state_r)
      SER_IDLE: begin
        if (rx_prev_r && !serial_in_pin_i) begin
          rx_state_nxt = SER_START;
          rx_restart = 1'b1;
        end
      end
      SER_START: begin
        if (rx_mid) begin
          rx_state_nxt = serial_in_pin_i ? SER_IDLE : SER_DATA;
          rx_cnt_nxt = 3'h0;
        end
      end
      SER_DATA: begin
        if (rx_mid) begin
          rx_sh_nxt = {serial_in_pin_i, rx_sh_r[7:1]};
          rx_cnt_nxt = rx_cnt_r + 3'h1;
          if (rx_cnt_r == len_last) begin
            rx_state_nxt = (par_mode == PAR_NONE) ? SER_STOP : SER_PARITY;
          end
        end
      end
      SER_PARITY: begin
        if (rx_mid) begin
          rx_par_nxt = serial_in_pin_i;
          rx_state_nxt = SER_STOP;
        end
      end
      SER_STOP: begin
        if (rx_mid) begin
          rx_done = 1'b1;
          rx_state_nxt = SER_IDLE;
        end
      end
      default: rx_state_nxt = SER_IDLE;
    endcase
    if (!mode_r.receive_enable_bit) begin
      rx_state_nxt = SER_IDLE;
      rx_done = 1'b0;
    end
    rx_err = rx_pe | rx_fe | rx_ove;
    irq_nxt = rx_done && !(rx_err && mode_r.error_irq_gating_bit);
  end

  // receiver state
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_state_r <= SER_IDLE;
      rx_sh_r <= RXBUF_RST;
      rx_cnt_r <= 3'h0;
      rx_par_r <= 1'b0;
      rx_prev_r <= 1'b1;
      irq_r <= 1'b0;
    end else if (ce_i) begin
      rx_state_r <= rx_state_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_par_r <= rx_par_nxt;
      rx_prev_r <= serial_in_pin_i;
      irq_r <= irq_nxt;
    end
  end

  assign rx_done_irq_o = irq_r;

  // ----------------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------------
  ser_state_t tx_state_r, tx_state_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [2:0] tx_cnt_r, tx_cnt_nxt;
  logic tx_par_r, tx_par_nxt, tx_out_r, tx_out_nxt, tx_stop2_r, tx_stop2_nxt;
  logic tx_busy_r, tx_busy_nxt;
  logic [7:0] tx_load;

  // framing: start, data LSB first, optional parity, one or two stops
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_par_nxt = tx_par_r;
    tx_out_nxt = tx_out_r;
    tx_stop2_nxt = tx_stop2_r;
    tx_restart = 1'b0;
    tx_load = mode_r.char_length_bit ? sfr_wdata_i : {1'b0, sfr_wdata_i[6:0]};
    unique case (tx_state_r)
      SER_IDLE: begin
        tx_out_nxt = 1'b1;
        if (wr_data && mode_r.transmit_enable_bit) begin
          tx_sh_nxt = tx_load;
          unique case (par_mode)
            PAR_ODD: tx_par_nxt = ~(^tx_load);
            PAR_EVEN: tx_par_nxt = ^tx_load;
            default: tx_par_nxt = 1'b0;
          endcase
          tx_out_nxt = 1'b0;
          tx_restart = 1'b1;
          tx_state_nxt = SER_START;
        end
      end
      SER_START: begin
        if (tx_end) begin
          tx_out_nxt = tx_sh_r[0];
          tx_sh_nxt = {1'b1, tx_sh_r[7:1]};
          tx_cnt_nxt = 3'h0;
          tx_state_nxt = SER_DATA;
        end
      end
      SER_DATA: begin
        if (tx_end) begin
          tx_cnt_nxt = tx_cnt_r + 3'h1;
          tx_out_nxt = tx_sh_r[0];
          tx_sh_nxt = {1'b1, tx_sh_r[7:1]};
          if (tx_cnt_r == len_last) begin
            tx_out_nxt = (par_mode == PAR_NONE) ? 1'b1 : tx_par_r;
            tx_stop2_nxt = 1'b0;
            tx_state_nxt = (par_mode == PAR_NONE) ? SER_STOP : SER_PARITY;
          end
        end
      end
      SER_PARITY: begin
        if (tx_end) begin
          tx_out_nxt = 1'b1;
          tx_state_nxt = SER_STOP;
        end
      end
      SER_STOP: begin
        if (tx_end) begin
          if (mode_r.stop_length_bit && !tx_stop2_r) begin
            tx_stop2_nxt = 1'b1;
          end else begin
            tx_state_nxt = SER_IDLE;
          end
        end
      end
      default: tx_state_nxt = SER_IDLE;
    endcase
    if (!mode_r.transmit_enable_bit) begin
      tx_state_nxt = SER_IDLE;
      tx_out_nxt = 1'b1;
    end
    tx_busy_nxt = (tx_state_nxt != SER_IDLE); // busy straight from a flop
  end

  // transmitter state
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_state_r <= SER_IDLE;
      tx_sh_r <= TXSH_RST;
      tx_cnt_r <= 3'h0;
      tx_par_r <= 1'b0;
      tx_out_r <= 1'b1;
      tx_stop2_r <= 1'b0;
      tx_busy_r <= 1'b0;
    end else if (ce_i) begin
      tx_state_r <= tx_state_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_par_r <= tx_par_nxt;
      tx_out_r <= tx_out_nxt;
      tx_stop2_r <= tx_stop2_nxt;
      tx_busy_r <= tx_busy_nxt;
    end
  end

  assign serial_out_pin_o = tx_out_r;
  assign tx_busy_o = tx_busy_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_BAUD_B7: assert property (
    ce_i && sfr_rd_i && sfr_addr_i == ADDR_BAUD |=> !sfr_rdata_o[7])
    else $error("baud bit 7 read as one");
  AST_RX_MSB: assert property (
    ce_i && rx_done && !mode_r.char_length_bit |=> !rx_buf_r[7])
    else $error("7-bit character with MSB set");
  AST_OVERRUN: assert property (
    ce_i && rx_done && rx_full_r && !rd_data |=> stat_r[STAT_OVE_BIT])
    else $error("overrun not flagged");
  AST_FRAMING: assert property (
    ce_i && rx_done && !serial_in_pin_i |=> stat_r[STAT_FE_BIT])
    else $error("framing error not flagged");
  AST_IRQ_GATED: assert property (
    ce_i && rx_done && rx_err && mode_r.error_irq_gating_bit
    |=> !rx_done_irq_o) else $error("interrupt raised for gated error");
  AST_IRQ_CLEAN: assert property (
    ce_i && rx_done && !rx_err |=> rx_done_irq_o)
    else $error("receive interrupt missing");
  AST_TX_START: assert property (
    ce_i && wr_data && !tx_busy_o && mode_r.transmit_enable_bit
    |=> !serial_out_pin_o && tx_busy_o) else $error("start bit not driven");
  AST_TX_STOPPED: assert property (
    ce_i && !mode_r.transmit_enable_bit |=> serial_out_pin_o && !tx_busy_o)
    else $error("transmitter active");
  AST_STOP_HIGH: assert property (
    tx_state_r == SER_STOP |-> serial_out_pin_o) else $error("stop bit low");
  AST_FREEZE: assert property (
    !ce_i |=> $stable(presc_r) && $stable(tx_state_r))
    else $error("state moved with enable low");

endmodule // uart_core

// File: rtl/uart_pkg.sv
// constants, field layouts and state types shared by the serial interface
package uart_pkg;

  // ----------------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE = 16'hFFA0;
  localparam logic [15:0] ADDR_STAT = 16'hFFA1;
  localparam logic [15:0] ADDR_BAUD = 16'hFFA2;
  localparam logic [15:0] ADDR_DATA = 16'hFFA3;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] RXBUF_RST = 8'hFF;
  localparam logic [7:0] TXSH_RST = 8'hFF;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ----------------------------------------------------------------------
  // field positions and counts
  // ----------------------------------------------------------------------
  localparam int STAT_PE_BIT = 2;
  localparam int STAT_FE_BIT = 1;
  localparam int STAT_OVE_BIT = 0;
  localparam logic [4:0] DIV_BASE = 5'h10;
  localparam logic [7:0] PRESC_ONE = 8'h01;
  localparam logic [2:0] LEN7_LAST = 3'h6;
  localparam logic [2:0] LEN8_LAST = 3'h7;

  // ----------------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic transmit_enable_bit;
    logic receive_enable_bit;
    logic parity_select_hi;
    logic parity_select_lo;
    logic char_length_bit;
    logic stop_length_bit;
    logic error_irq_gating_bit;
    logic zero;
  } mode_t;

  typedef struct packed {
    logic zero;
    logic [2:0] prescale_sel;
    logic [3:0] divider_sel;
  } baud_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD = 2'b10,
    PAR_EVEN = 2'b11
  } parity_t;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PARITY = 3'b011,
    SER_STOP = 3'b100
  } ser_state_t;

endpackage

// File: tb/serial_peer.sv
// remote serial station: sends frames to the core and decodes its frames
`timescale 1ns/1ps
module serial_peer (
  input wire logic ref_clk_i,
  input wire logic line_i,
  output logic line_o,
  input wire logic len8_i,
  input wire logic [1:0] par_i,
  input wire logic [15:0] period_i
);
  logic [7:0] got_q[$];
  logic got_par_q[$];
  logic stop_ok_q[$];

  // line rests at mark level between frames
  initial line_o = 1'b1;

  // ----------------------------------------------------------------------
  // sender: start, data lsb first, optional parity, one stop slot
  // ----------------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic pb, input logic sb);
    line_o = 1'b0;
    repeat (period_i) @(negedge ref_clk_i);
    for (int b = 0; b < (len8_i ? 8 : 7); b++) begin
      line_o = d[b];
      repeat (period_i) @(negedge ref_clk_i);
    end
    if (par_i != 2'b00) begin
      line_o = pb;
      repeat (period_i) @(negedge ref_clk_i);
    end
    line_o = sb; // a low slot here breaks the frame on purpose
    repeat (period_i) @(negedge ref_clk_i);
    if (!sb) begin
      line_o = 1'b1;
    end
  endtask

  // ----------------------------------------------------------------------
  // receiver: samples each slot at its middle
  // ----------------------------------------------------------------------
  initial begin : rx_proc
    logic [7:0] d;
    forever begin
      @(negedge line_i);
      repeat (period_i / 2) @(posedge ref_clk_i);
      d = 8'h00;
      for (int b = 0; b < (len8_i ? 8 : 7); b++) begin
        repeat (period_i) @(posedge ref_clk_i);
        d[b] = line_i;
      end
      if (par_i != 2'b00) begin
        repeat (period_i) @(posedge ref_clk_i);
        got_par_q.push_back(line_i);
      end
      repeat (period_i) @(posedge ref_clk_i);
      stop_ok_q.push_back(line_i);
      got_q.push_back(d);
    end
  end
endmodule // serial_peer

// File: tb/tb_top.sv
// self-checking bench for the serial interface core
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin \
  logic [31:0] e_, g_; \
  e_ = 32'(exp); \
  g_ = 32'(got); \
  comparisons++; \
  if (g_ !== e_) begin \
    errors++; \
    $display("unexpected %s: expected %0h seen %0h", what, e_, g_); \
  end \
end
module tb_top
  import uart_pkg::*;
;
  logic ref_clk_i, arst_n_i, ce_i, sfr_wr_i, sfr_rd_i, serial_in_pin_i;
  logic [15:0] sfr_addr_i;
  logic [7:0] sfr_wdata_i, sfr_rdata_o, rnd, cur_mode;
  logic serial_out_pin_o, rx_pin_serial_o, tx_pin_serial_o;
  logic rx_done_irq_o, tx_busy_o, peer_len8;
  logic [1:0] peer_par;
  logic [15:0] peer_period;
  logic [7:0] bauds[3] = '{8'h0E, 8'h13, 8'h2E};
  int errors = 0, comparisons = 0, cycles = 0, irq_cnt = 0;
  localparam int LIMIT = 60000;

  uart_core uart_core_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .ce_i(ce_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o),
    .rx_pin_serial_o(rx_pin_serial_o), .tx_pin_serial_o(tx_pin_serial_o),
    .rx_done_irq_o(rx_done_irq_o), .tx_busy_o(tx_busy_o));
  serial_peer serial_peer_i (.ref_clk_i(ref_clk_i),
    .line_i(serial_out_pin_o), .line_o(serial_in_pin_i),
    .len8_i(peer_len8), .par_i(peer_par), .period_i(peer_period));

  // 50 ns clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // cycle ceiling and receive interrupt pulse count, away from launch edge
  always @(negedge ref_clk_i) begin
    cycles++;
    if (rx_done_irq_o === 1'b1) irq_cnt++;
    if (cycles == LIMIT) begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // reference model and bus tasks
  // ----------------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] chr(input logic [7:0] d);
    return peer_len8 ? d : {1'b0, d[6:0]};
  endfunction
  function automatic logic par_bit(input logic [7:0] d);
    case (peer_par)
      2'b10: return ~^chr(d);
      2'b11: return ^chr(d);
      default: return 1'b0;
    endcase
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
    @(negedge ref_clk_i);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHECK($sformatf("read of %h", a), e, v)
  endtask
  task automatic cfg(input logic [1:0] p, input logic l8, s, g,
                     input logic [7:0] b);
    wr(ADDR_BAUD, b);
    cur_mode = {2'b11, p, l8, s, g, 1'b0};
    wr(ADDR_MODE, cur_mode);
    peer_par = p;
    peer_len8 = l8;
    peer_period = 16'((2 << b[6:4]) * (16 + b[3:0]));
  endtask
  task automatic tx_one(input logic [7:0] d);
    int n, e, t;
    logic ok, pb;
    n = 0;
    e = 2 + (peer_len8 ? 8 : 7) + (peer_par != 2'b00) + cur_mode[2];
    e = e * peer_period;
    t = peer_period / 16 + 2;
    wr(ADDR_DATA, d);
    while (tx_busy_o === 1'b1 && n < 40000) begin
      @(negedge ref_clk_i);
      n++;
    end
    ok = (n + 1 >= e - t) && (n + 1 <= e + t);
    `CHECK("tx frame length", 1'b1, ok)
    `CHECK("tx frames", 1, serial_peer_i.got_q.size())
    `CHECK("tx data", chr(d), serial_peer_i.got_q.pop_front())
    if (peer_par != 2'b00) begin
      pb = serial_peer_i.got_par_q.pop_front();
      `CHECK("tx parity", par_bit(d), pb)
    end
    `CHECK("tx stop", 1'b1, serial_peer_i.stop_ok_q.pop_front())
  endtask
  task automatic rx_one(input logic [7:0] d, input logic bp, bs,
                        input logic [7:0] st, input int ni, rb);
    int i0;
    logic [7:0] v;
    i0 = irq_cnt;
    serial_peer_i.send(d, par_bit(d) ^ bp, ~bs);
    repeat (4) @(negedge ref_clk_i);
    `CHECK("rx irq count", ni, irq_cnt - i0)
    rd(ADDR_STAT, v);
    `CHECK("rx status", st, v)
    if (rb != 0) begin
      rd(ADDR_DATA, v);
      if (rb == 1) `CHECK("rx data", chr(d), v)
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int i0;
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    sfr_addr_i = 16'h0000;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_wdata_i = 8'h00;
    peer_len8 = 1'b0;
    peer_par = 2'b00;
    peer_period = 16'h0020;
    cur_mode = 8'h00;
    rnd = 8'h0A;
    repeat (20) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    rd_chk(ADDR_MODE, MODE_RST);
    rd_chk(ADDR_STAT, STAT_RST);
    rd_chk(ADDR_BAUD, BAUD_RST);
    rd_chk(ADDR_DATA, RXBUF_RST);
    rd_chk(16'hFFA4, UNMAPPED_RD);
    wr(ADDR_DATA, 8'h5A);
    `CHECK("stopped tx busy", 1'b0, tx_busy_o)
    wr(ADDR_BAUD, 8'hFF);
    rd_chk(ADDR_BAUD, 8'h7F);
    wr(ADDR_STAT, 8'hFF);
    rd_chk(ADDR_STAT, 8'h00);
    wr(ADDR_MODE, 8'hFF);
    rd_chk(ADDR_MODE, 8'hFE);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE, {m[1:0], 6'h00});
      `CHECK("rx pin use", m[0], rx_pin_serial_o)
      `CHECK("tx pin use", m[1], tx_pin_serial_o)
    end
    // a write while the clock enable is low must leave the mode untouched
    ce_i = 1'b0;
    wr(ADDR_MODE, 8'h00);
    ce_i = 1'b1;
    `CHECK("frozen tx pin use", 1'b1, tx_pin_serial_o)
    rd_chk(ADDR_MODE, 8'hC0);
    done("registers");
    for (int c = 0; c < 16; c++) begin
      cfg(c[3:2], c[1], c[0], 1'b0, 8'h00);
      rnd = lfsr_next(rnd);
      tx_one(rnd);
      rnd = lfsr_next(rnd);
      rx_one(rnd, 1'b0, 1'b0, 8'h00, 1, 1);
    end
    done("formats");
    for (int j = 0; j < 3; j++) begin
      cfg(2'b11, 1'b1, 1'b0, 1'b0, bauds[j]);
      rnd = lfsr_next(rnd);
      tx_one(rnd);
      rnd = lfsr_next(rnd);
      rx_one(rnd, 1'b0, 1'b0, 8'h00, 1, 1);
    end
    done("baud");
    cfg(2'b10, 1'b1, 1'b0, 1'b1, 8'h00);
    rx_one(8'h3C, 1'b1, 1'b0, 8'h04, 0, 2);
    cfg(2'b11, 1'b1, 1'b0, 1'b0, 8'h00);
    rx_one(8'hA5, 1'b1, 1'b0, 8'h04, 1, 2);
    rx_one(8'h5A, 1'b0, 1'b1, 8'h02, 1, 2);
    cfg(2'b11, 1'b1, 1'b0, 1'b1, 8'h00);
    rx_one(8'h5A, 1'b0, 1'b1, 8'h02, 0, 2);
    cfg(2'b01, 1'b0, 1'b0, 1'b1, 8'h00);
    rx_one(8'h7E, 1'b1, 1'b0, 8'h00, 1, 1);
    done("errors");
    cfg(2'b00, 1'b1, 1'b1, 1'b0, 8'h00);
    i0 = irq_cnt;
    serial_peer_i.send(8'h11, 1'b0, 1'b1);
    serial_peer_i.send(8'h22, 1'b0, 1'b1);
    repeat (4) @(negedge ref_clk_i);
    `CHECK("back to back irqs", 2, irq_cnt - i0)
    rd_chk(ADDR_STAT, 8'h01);
    rx_one(8'h33, 1'b0, 1'b0, 8'h01, 1, 0);
    rd_chk(ADDR_DATA, 8'h33);
    rx_one(8'h44, 1'b0, 1'b0, 8'h00, 1, 1);
    done("overrun");
    end_sim();
  end
endmodule // tb_top
